// ==== pkg/dsl_regs.vh ====
/*
 * Constants for the serial load front end: word layout, field positions,
 * reset values of the channel registers.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef DSL_REGS_VH
`define DSL_REGS_VH

`define DSL_WORD_BITS 16
`define DSL_CNT_W 5
`define DSL_CNT_FULL 5'h10
`define DSL_CNT_ZERO 5'h00
`define DSL_CNT_ONE 5'h01
`define DSL_DATA_W 10
`define DSL_TRIM_W 8
`define DSL_MODE_BIT 15
`define DSL_ADDR_HI 14
`define DSL_ADDR_LO 12
`define DSL_ADDR_W 3
`define DSL_DATA_HI 9
`define DSL_DATA_LO 0
`define DSL_EXTB_BIT 0
`define DSL_SIXT_BIT 1
`define DSL_TRIM_HI 9
`define DSL_TRIM_LO 2
`define DSL_CODE_RESET 10'h200
`define DSL_TRIM_RESET 8'h80
`define DSL_SYNC_IDLE 5'h1F

`endif

// ==== rtl/dsl_top.v ====
/*
 * Serial word loader for a multi-channel DAC: pin sampling, 16-bit shift
 * register, word FIFO, data/control/DAC registers, update and clear.
 * Assumes all serial pins are asynchronous to CLK and that the serial
 * clock is well below CLK/4.
 */
// Operation
// [R1] strobe low copies all data registers simultaneously
// [R2] strobe low at sixteenth edge auto-updates
// [R3] one transfer is exactly one 16-bit word
// [R4] data sampled on serial clock falling edges
// [R5] clear forces main outputs to bias level
// [R6] clear also re-centres every sub DAC trim
// [R7] channel control selects external bias point
// [R8] shift register accepts only while frame low
// [R9] word moves on after sixteenth bit; extras ignored
`include "dsl_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module dsl_fifo #(
  parameter WIDTH = 17,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // fill side
  input wire in_valid,
  input wire [WIDTH-1:0] in_data,
  output wire in_ready,
  // drain side
  output wire out_valid,
  output wire [WIDTH-1:0] out_data,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr_reg;
  reg [AW:0] rd_ptr_reg;
  wire full;
  wire empty;

  assign empty = (wr_ptr_reg == rd_ptr_reg);
  assign full = (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]) &&
                (wr_ptr_reg[AW] != rd_ptr_reg[AW]);
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign out_data = mem[rd_ptr_reg[AW-1:0]];

  always @(posedge clk) begin
    if (in_valid && !full) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= {(AW+1){1'b0}};
      rd_ptr_reg <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule

module dsl_top #(
  parameter CHANNELS = 4,
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  // clock and reset
  input wire CLK,
  input wire RESET,
  // serial port pins
  input wire SERIAL_SHIFT_CLOCK,
  input wire SERIAL_WORD_INPUT,
  input wire WORD_FRAME_SYNC_N,
  input wire DAC_UPDATE_STROBE_N,
  input wire ASYNC_OUTPUT_CLEAR_N,
  // per-channel outputs to the analog core
  output reg [CHANNELS*`DSL_DATA_W-1:0] DAC_CODE,
  output reg [CHANNELS*`DSL_TRIM_W-1:0] SUB_DAC_TRIM,
  output reg [CHANNELS-1:0] EXTERNAL_BIAS_SELECT,
  output reg [CHANNELS-1:0] CLEAR_TO_SIXTEENTH,
  // status
  output reg CLEAR_ACTIVE,
  output reg WORD_OVERRUN
);
  localparam FW = `DSL_WORD_BITS + 1;

  // two-flop synchronisers; stage one is read only by stage two
  reg [4:0] sync1_reg;
  reg [4:0] sync2_reg;
  reg sclk_prev_reg;
  wire sclk_s = sync2_reg[0];
  wire serial_word_input_s = sync2_reg[1];
  wire frame_n_s = sync2_reg[2];
  wire strobe_n_s = sync2_reg[3];
  wire clear_n_s = sync2_reg[4];
  wire sclk_fall = sclk_prev_reg & ~sclk_s;

  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      sync1_reg <= `DSL_SYNC_IDLE;
      sync2_reg <= `DSL_SYNC_IDLE;
      sclk_prev_reg <= 1'b1;
    end else begin
      sync1_reg <= {ASYNC_OUTPUT_CLEAR_N, DAC_UPDATE_STROBE_N, WORD_FRAME_SYNC_N,
                    SERIAL_WORD_INPUT, SERIAL_SHIFT_CLOCK};
      sync2_reg <= sync1_reg;
      sclk_prev_reg <= sclk_s;
    end
  end

  // input shift register
  reg [`DSL_WORD_BITS-1:0] shift_reg;
  reg [`DSL_CNT_W-1:0] count_reg;
  reg push_reg;
  reg push_strobe_reg;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [FW-1:0] fifo_out_data;
  wire fifo_out_ready;

  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      shift_reg <= {`DSL_WORD_BITS{1'b0}};
      count_reg <= `DSL_CNT_ZERO;
      push_reg <= 1'b0;
      push_strobe_reg <= 1'b0;
      WORD_OVERRUN <= 1'b0;
    end else begin
      push_reg <= 1'b0;
      if (frame_n_s) begin
        count_reg <= `DSL_CNT_ZERO; // R8
      end else if (sclk_fall && count_reg != `DSL_CNT_FULL) begin // R9
        shift_reg <= {shift_reg[`DSL_WORD_BITS-2:0], serial_word_input_s}; // R4
        count_reg <= count_reg + `DSL_CNT_ONE;
        if (count_reg == `DSL_CNT_FULL - `DSL_CNT_ONE) begin // R3
          push_reg <= 1'b1;
          push_strobe_reg <= ~strobe_n_s; // R2
        end
      end
      // a word arriving with the FIFO full is lost; flag it until reset
      if (push_reg && !fifo_in_ready) begin
        WORD_OVERRUN <= 1'b1;
      end
    end
  end

  dsl_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(CLK),
    .rst(RESET),
    .in_valid(push_reg),
    .in_data({push_strobe_reg, shift_reg}),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(fifo_out_ready)
  );

  // drain stalls while clear is held so no word lands mid-clear
  assign fifo_out_ready = clear_n_s;
  wire take = fifo_out_valid & fifo_out_ready;
  wire [`DSL_WORD_BITS-1:0] word = fifo_out_data[`DSL_WORD_BITS-1:0];
  wire auto_upd = fifo_out_data[`DSL_WORD_BITS];
  wire [`DSL_ADDR_W-1:0] addr = word[`DSL_ADDR_HI:`DSL_ADDR_LO];
  wire is_data = word[`DSL_MODE_BIT];

  // channel registers
  reg [`DSL_DATA_W-1:0] data_reg [0:CHANNELS-1];
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_ch
      wire hit = take && (addr == ch);
      always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
          data_reg[ch] <= `DSL_CODE_RESET;
          DAC_CODE[ch*`DSL_DATA_W +: `DSL_DATA_W] <= `DSL_CODE_RESET;
          SUB_DAC_TRIM[ch*`DSL_TRIM_W +: `DSL_TRIM_W] <= `DSL_TRIM_RESET;
          EXTERNAL_BIAS_SELECT[ch] <= 1'b0;
          CLEAR_TO_SIXTEENTH[ch] <= 1'b0;
        end else if (!clear_n_s) begin
          DAC_CODE[ch*`DSL_DATA_W +: `DSL_DATA_W] <= `DSL_CODE_RESET; // R5
          SUB_DAC_TRIM[ch*`DSL_TRIM_W +: `DSL_TRIM_W] <= `DSL_TRIM_RESET; // R6
        end else begin
          if (hit && is_data) begin
            data_reg[ch] <= word[`DSL_DATA_HI:`DSL_DATA_LO];
          end
          if (hit && !is_data) begin
            EXTERNAL_BIAS_SELECT[ch] <= word[`DSL_EXTB_BIT]; // R7
            CLEAR_TO_SIXTEENTH[ch] <= word[`DSL_SIXT_BIT];
            SUB_DAC_TRIM[ch*`DSL_TRIM_W +: `DSL_TRIM_W] <= word[`DSL_TRIM_HI:`DSL_TRIM_LO];
          end
          if (!strobe_n_s) begin
            DAC_CODE[ch*`DSL_DATA_W +: `DSL_DATA_W] <= data_reg[ch]; // R1
          end else if (take && auto_upd) begin
            // the fresh word is bypassed so the auto update carries it
            DAC_CODE[ch*`DSL_DATA_W +: `DSL_DATA_W] <=
              (hit && is_data) ? word[`DSL_DATA_HI:`DSL_DATA_LO] : data_reg[ch]; // R2
          end
        end
      end
    end
  endgenerate

  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      CLEAR_ACTIVE <= 1'b0;
    end else begin
      CLEAR_ACTIVE <= ~clear_n_s; // R5
    end
  end
endmodule

`default_nettype wire

// ==== test/dsl_checker.sv ====
/* pin assertions for dsl_top
   assumes the bind below and one CLK domain */
`timescale 1ns/1ps
`default_nettype none
module dsl_checker #(parameter CHANNELS = 4) (
  // clock, reset, pins
  input wire CLK,
  input wire RESET,
  input wire WORD_FRAME_SYNC_N,
  input wire DAC_UPDATE_STROBE_N,
  input wire ASYNC_OUTPUT_CLEAR_N,
  // outputs
  input wire [CHANNELS*10-1:0] DAC_CODE,
  input wire [CHANNELS*8-1:0] SUB_DAC_TRIM,
  input wire [CHANNELS-1:0] EXTERNAL_BIAS_SELECT,
  input wire CLEAR_ACTIVE,
  input wire WORD_OVERRUN
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  // five samples allow for the two-flop sync and the forcing edge
  sequence clr_held; (!ASYNC_OUTPUT_CLEAR_N) [*5]; endsequence
  sequence clr_off; ASYNC_OUTPUT_CLEAR_N [*5]; endsequence
  sequence idle8; (WORD_FRAME_SYNC_N && ASYNC_OUTPUT_CLEAR_N) [*8]; endsequence
  sequence quiet8; (WORD_FRAME_SYNC_N && ASYNC_OUTPUT_CLEAR_N && DAC_UPDATE_STROBE_N) [*8]; endsequence
  AST_CLR_CODE: assert property (clr_held |-> DAC_CODE == {CHANNELS{10'h200}})
    else $error("code not cleared");
  AST_CLR_TRIM: assert property (clr_held |-> SUB_DAC_TRIM == {CHANNELS{8'h80}})
    else $error("trim not cleared");
  AST_CLR_FLAG: assert property (clr_held |-> CLEAR_ACTIVE)
    else $error("clear flag low");
  AST_CLR_END: assert property (clr_off |-> !CLEAR_ACTIVE)
    else $error("clear flag stuck");
  AST_QUIET_CODE: assert property (quiet8 |=> $stable(DAC_CODE))
    else $error("code moved while idle");
  AST_QUIET_TRIM: assert property (idle8 |=> $stable(SUB_DAC_TRIM))
    else $error("trim moved while idle");
  AST_QUIET_SEL: assert property (idle8 |=> $stable(EXTERNAL_BIAS_SELECT))
    else $error("select moved while idle");
  AST_OVR_STICKY: assert property (WORD_OVERRUN |=> WORD_OVERRUN)
    else $error("overrun dropped");
endmodule
bind dsl_top dsl_checker #(.CHANNELS(CHANNELS)) chk_u (.CLK, .RESET, .WORD_FRAME_SYNC_N,
  .DAC_UPDATE_STROBE_N, .ASYNC_OUTPUT_CLEAR_N, .DAC_CODE, .SUB_DAC_TRIM,
  .EXTERNAL_BIAS_SELECT, .CLEAR_ACTIVE, .WORD_OVERRUN);
`default_nettype wire

// ==== test/dsl_host.sv ====
/* host model of the three-wire serial port
   assumes one send at a time */
`timescale 1ns/1ps
`default_nettype none
module dsl_host (
  // serial pins
  output logic sck,
  output logic sdi,
  output logic fs_n
);
  initial begin
    sck = 1;
    sdi = 0;
    fs_n = 1;
  end
  // clock idles high between frames; data inverted once released
  task automatic send(input logic [15:0] w, input int n);
    fs_n = 0;
    for (int i = 0; i < n; i++) begin
      sdi = w[15 - i % 16];
      #100 sck = 0;
      #100 sck = 1;
    end
    #100 fs_n = 1;
    sdi = ~sdi;
  endtask
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
/* self-checking bench for dsl_top
   assumes dsl_host drives the serial pins */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 0, rst = 1, ld_n = 1, clr_n = 1;
  wire sck, sdi, fs_n, cact, ovr;
  wire [39:0] code;
  wire [31:0] trim;
  wire [3:0] extb, sixt;
  logic [39:0] model, code_q, q[$];
  int n_mismatch = 0, n_compared = 0;
  dsl_top dut_u (.CLK(clk), .RESET(rst), .SERIAL_SHIFT_CLOCK(sck), .SERIAL_WORD_INPUT(sdi),
    .WORD_FRAME_SYNC_N(fs_n), .DAC_UPDATE_STROBE_N(ld_n), .ASYNC_OUTPUT_CLEAR_N(clr_n),
    .DAC_CODE(code), .SUB_DAC_TRIM(trim), .EXTERNAL_BIAS_SELECT(extb),
    .CLEAR_TO_SIXTEENTH(sixt), .CLEAR_ACTIVE(cact), .WORD_OVERRUN(ovr));
  dsl_host host_u (.sck(sck), .sdi(sdi), .fs_n(fs_n));
  initial forever #12.5 clk = ~clk;
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic pins(input logic l, input logic c);
    @(posedge clk) #2;
    ld_n = l;
    clr_n = c;
  endtask
  task automatic pulse;
    repeat (10) @(posedge clk);
    q.push_back(model);
    pins(0, 1);
    pins(1, 1);
  endtask
  // looked at mid-cycle so a multi-channel update counts as one result
  always @(negedge clk) begin
    if (!rst && code !== code_q) chk(code, q.size() ? q.pop_front() : 40'hX);
    code_q <= code;
  end
  initial begin
    logic [2:0] ch;
    logic [9:0] v;
    logic [31:0] tm;
    logic [3:0] em, sm;
    tm = 32'h80808080;
    em = 0;
    sm = 0;
    model = {4{10'h200}};
    void'($urandom(32'h05A3));
    repeat (6) @(posedge clk);
    #2 rst = 0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 12; i++) begin
      ch = $urandom % 4;
      v = $urandom;
      // a repeated value would leave no visible update to pair with
      while (v == model[ch*10+:10] || v == code[ch*10+:10]) v = $urandom;
      if (i == 5) host_u.send(16'hFFFF, 8);
      model[ch*10+:10] = v;
      if (i % 3 == 0) q.push_back(model);
      pins(i % 3 != 0 || i % 6 == 3, 1);
      // strobe low only around the sixteenth falling edge
      if (i % 6 == 3) fork
        begin
          #3050 ld_n = 0;
          #100 ld_n = 1;
        end
      join_none
      host_u.send({1'b1, ch, 2'b00, v}, i % 4 == 1 ? 20 : 16);
      pins(1, 1);
      if (i % 3 == 2) pulse;
    end
    for (int c = 0; c < 4; c++) begin
      v = $urandom;
      tm[c*8+:8] = v[9:2];
      sm[c] = v[1];
      em[c] = v[0];
      host_u.send({1'b0, c[2:0], 2'b00, v}, 16);
      repeat (12) @(posedge clk);
      chk({trim, extb, sixt}, {tm, em, sm});
    end
    chk({39'h0, ovr}, 40'h0);
    q.push_back({4{10'h200}});
    pins(1, 0);
    repeat (10) @(posedge clk);
    chk({trim, extb, sixt}, {32'h80808080, em, sm});
    chk({39'h0, cact}, 40'h1);
    // drain stalls under clear: nine words overfill the eight-deep FIFO
    v = $urandom;
    tm = {24'h808080, v[9:2]};
    em[0] = v[0];
    sm[0] = v[1];
    for (int k = 0; k < 9; k++) begin
      host_u.send({1'b0, 3'h0, 2'b00, v}, 16);
      repeat (2) pins(1, 0);
    end
    chk({39'h0, ovr}, 40'h1);
    pins(1, 1);
    pulse;
    repeat (10) @(posedge clk);
    chk({trim, extb, sixt}, {tm, em, sm});
    chk({39'h0, ovr}, 40'h1);
    if (q.size() != 0) begin
      n_mismatch++;
      $display("Error %0t: expected update never seen", $time);
    end
    final_report;
  end
  initial begin
    #300000;
    n_mismatch++;
    $display("Error %0t: timeout", $time);
    final_report;
  end
  task final_report;
    if (n_mismatch == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
endmodule
`default_nettype wire
